// ### hw/rwrb_bank.sv
`timescale 1ns/10ps
`include "rwrb_defs.svh"
module rwrb_bank import rwrb_pkg::*; (
	// Clock, reset, enable
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  clk_en_i,
	// Serial command port
	input  wire logic                  command_serial_clock_i,
	input  wire logic                  command_serial_in_i,
	input  wire logic                  chip_enable_i,
	input  wire logic [`RWRB_ADDR_W-1:0] addr_i,
	input  wire logic                  addr_valid_i,
	// Status from the clock core
	input  wire logic                  pll_locked_i,
	// Decoded controls
	output logic                       soft_reset_o,
	output logic [1:0]                 power_down_mode_o,
	output logic                       vco_run_o,
	output logic [1:0]                 locked_clock_ratio_o,
	output logic                       pll_base_512_o,
	output logic                       pll_post_half_o,
	output logic                       output_clock_halving_o,
	output logic                       amp_run_o,
	output logic                       use_crystal_o,
	output logic [3:0]                 crystal_frequency_code_o,
	output logic                       crystal_loopback_o,
	output logic                       ratio_reload_o,
	output logic [`RWRB_DATA_W-1:0]    port_settings_o,
	output logic [`RWRB_DATA_W-1:0]    irq_settings_o
);
	logic       rst_s1_q, rst_s2_q;
	logic       sck_q, sck_d;
	logic [`RWRB_DATA_W-1:0] sh_q, sh_d;
	logic [`RWRB_CNT_W-1:0]  cnt_q, cnt_d;
	rwrb_sel_t  sel_q, sel_d;
	logic       we_q, we_d;
	logic       srst_q, srst_d;
	logic [`RWRB_DATA_W-1:0] sys, port, irq;
	logic [1:0] pd_q, pd_d, rat_q, rat_d;
	logic       base_q, base_d, post_q, post_d, reld_q, reld_d;
	logic       vco_q, vco_d, half_q, half_d, amp_q, amp_d, src_q, src_d;
	logic [3:0] xf_q, xf_d;
	logic       lb_q, lb_d;
	rwrb_xtal_t xtal;

	rwrb_wr_if wr();

	// Reset release through two flops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// Serial receive: shift on rising serial clock, load after 16th bit
	always_comb begin
		sck_d  = command_serial_clock_i;
		sh_d   = sh_q;
		cnt_d  = cnt_q;
		sel_d  = sel_q;
		we_d   = 1'b0;
		if (!chip_enable_i) begin
			cnt_d = `RWRB_CNT_ZERO;
			if (addr_valid_i) begin
				unique case (addr_i)
					`RWRB_ADDR_SYS:  sel_d = SEL_SYS;
					`RWRB_ADDR_PORT: sel_d = SEL_PORT;
					`RWRB_ADDR_IRQ:  sel_d = SEL_IRQ;
					default:         sel_d = SEL_NONE;
				endcase
			end
		end else if (command_serial_clock_i && !sck_q && sel_q != SEL_NONE
			&& cnt_q != `RWRB_CNT_FULL) begin
			sh_d  = {command_serial_in_i, sh_q[`RWRB_DATA_W-1:1]};
			cnt_d = cnt_q + `RWRB_CNT_ONE;
			// Extra clocks beyond 16 are ignored, never reloaded
			we_d  = (cnt_q + `RWRB_CNT_ONE) == `RWRB_CNT_FULL;
		end
	end

	always_ff @(posedge clk_i or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			sck_q <= 1'b0;
			sh_q  <= '0;
			cnt_q <= `RWRB_CNT_ZERO;
			sel_q <= SEL_NONE;
			we_q  <= 1'b0;
		end else if (clk_en_i) begin
			sck_q <= sck_d;
			sh_q  <= sh_d;
			cnt_q <= cnt_d;
			sel_q <= sel_d;
			we_q  <= we_d;
		end
	end

	assign wr.we   = we_q;
	assign wr.sel  = sel_q;
	assign wr.data = sh_q;

	// Receive checks
	a_load_after_word: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		wr.we && $past(clk_en_i) |-> $past(cnt_q) == `RWRB_CNT_FULL - `RWRB_CNT_ONE)
		else $error("load without full word");
	a_word_count: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		cnt_q <= `RWRB_CNT_FULL)
		else $error("bit count beyond one word");
	a_no_partial: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && !chip_enable_i |=> !wr.we)
		else $error("load outside data phase");
	a_deselect_hold: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && sel_q == SEL_NONE |=> !wr.we)
		else $error("load to unknown address");
	a_select_sys: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && !chip_enable_i && addr_valid_i && addr_i == `RWRB_ADDR_SYS
		|=> sel_q == SEL_SYS)
		else $error("system address not selected");
	a_select_other: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && !chip_enable_i && addr_valid_i && addr_i != `RWRB_ADDR_SYS
		&& addr_i != `RWRB_ADDR_PORT && addr_i != `RWRB_ADDR_IRQ |=> sel_q == SEL_NONE)
		else $error("foreign address selected");
	a_bit_shift: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && chip_enable_i && command_serial_clock_i && !sck_q && sel_q != SEL_NONE
		&& cnt_q != `RWRB_CNT_FULL |=> sh_q[`RWRB_DATA_W-1] == $past(command_serial_in_i))
		else $error("serial bit not taken");
	a_no_edge_hold: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && !(command_serial_clock_i && !sck_q) |=> $stable(sh_q))
		else $error("shift without rising serial clock");

	rwrb_store u_store (
		.clk_i   (clk_i),
		.rst_n_i (rst_s2_q),
		.ce_i    (clk_en_i),
		.wr      (wr.dst),
		.sys_o   (sys),
		.port_o  (port),
		.irq_o   (irq)
	);

	assign xtal = rwrb_xtal_t'(sys[`RWRB_B_XF_HI-1:`RWRB_B_XF_LO]);

	// Decode of system settings
	always_comb begin
		srst_d = sys[`RWRB_B_SRST];
		pd_d   = sys[`RWRB_B_PD_HI:`RWRB_B_PD_LO];
		if (pd_d == PD_RSVD) begin
			pd_d = PD_NORMAL;
		end
		vco_d  = ~sys[`RWRB_B_VCO];
		rat_d  = sys[`RWRB_B_RAT_HI:`RWRB_B_RAT_LO];
		// 512 base kept for both 10 and 11 so a move between 10 and 11 never relocks the VCO
		base_d = rat_d[1];
		post_d = (rat_d == RAT_512H);
		// Reload request only on a ratio move that needs relock
		reld_d = (rat_d != rat_q) && !(rat_d[1] && rat_q[1]);
		half_d = sys[`RWRB_B_HALF];
		amp_d  = ~sys[`RWRB_B_AMPSTOP]
			&& (sys[`RWRB_B_AMPCONT] || !pll_locked_i);
		src_d  = sys[`RWRB_B_SRC] || !pll_locked_i;
		xf_d   = sys[`RWRB_B_XF_HI:`RWRB_B_XF_LO];
		lb_d   = sys[`RWRB_B_XF_MSB];
	end

	always_ff @(posedge clk_i or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			srst_q <= 1'b0;
			pd_q   <= PD_NORMAL;
			vco_q  <= 1'b1;
			rat_q  <= RAT_256;
			base_q <= 1'b0;
			post_q <= 1'b0;
			reld_q <= 1'b0;
			half_q <= 1'b0;
			amp_q  <= 1'b1;
			src_q  <= 1'b1;
			xf_q   <= 4'h0;
			lb_q   <= 1'b0;
		end else if (clk_en_i) begin
			srst_q <= srst_d;
			pd_q   <= pd_d;
			vco_q  <= vco_d;
			rat_q  <= rat_d;
			base_q <= base_d;
			post_q <= post_d;
			reld_q <= reld_d;
			half_q <= half_d;
			amp_q  <= amp_d;
			src_q  <= src_d;
			xf_q   <= xf_d;
			lb_q   <= lb_d;
		end
	end

	assign soft_reset_o             = srst_q;
	assign power_down_mode_o        = pd_q;
	assign vco_run_o                = vco_q;
	assign locked_clock_ratio_o     = rat_q;
	assign pll_base_512_o           = base_q;
	assign pll_post_half_o          = post_q;
	assign ratio_reload_o           = reld_q;
	assign output_clock_halving_o   = half_q;
	assign amp_run_o                = amp_q;
	assign use_crystal_o            = src_q;
	assign crystal_frequency_code_o = xf_q;
	assign crystal_loopback_o       = lb_q;
	assign port_settings_o          = port;
	assign irq_settings_o           = irq;

	// Register and decode checks
	a_reserved_zero: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		(sys & `RWRB_SYS_RSVD) == '0 && (port & `RWRB_PORT_RSVD) == '0
		&& (irq & `RWRB_IRQ_RSVD) == '0)
		else $error("reserved bit stored");
	a_sys_load: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && wr.we && wr.sel == SEL_SYS |=> sys == ($past(sh_q) & ~`RWRB_SYS_RSVD))
		else $error("system register not loaded");
	a_port_load: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && wr.we && wr.sel == SEL_PORT |=> port == ($past(sh_q) & ~`RWRB_PORT_RSVD))
		else $error("port register not loaded");
	a_irq_load: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && wr.we && wr.sel == SEL_IRQ |=> irq == ($past(sh_q) & ~`RWRB_IRQ_RSVD))
		else $error("interrupt register not loaded");
	a_reg_hold: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && !wr.we |=> $stable(sys) && $stable(port) && $stable(irq))
		else $error("register changed without load");
	a_srst_follow: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i |=> soft_reset_o == $past(sys[`RWRB_B_SRST]))
		else $error("soft reset mismatch");
	a_pd_legal: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		power_down_mode_o != PD_RSVD)
		else $error("reserved power mode");
	a_pd_map: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && sys[`RWRB_B_PD_HI:`RWRB_B_PD_LO] != PD_RSVD
		|=> power_down_mode_o == $past(sys[`RWRB_B_PD_HI:`RWRB_B_PD_LO]))
		else $error("power mode mismatch");
	a_vco_stop: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && sys[`RWRB_B_VCO] |=> !vco_run_o)
		else $error("vco not stopped");
	a_vco_run: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && !sys[`RWRB_B_VCO] |=> vco_run_o)
		else $error("vco not running");
	a_ratio_follow: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i |=> locked_clock_ratio_o == $past(sys[`RWRB_B_RAT_HI:`RWRB_B_RAT_LO]))
		else $error("ratio mismatch");
	a_ratio_half: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i |=> pll_post_half_o == ($past(sys[`RWRB_B_RAT_HI:`RWRB_B_RAT_LO]) == RAT_512H))
		else $error("ratio halving mismatch");
	a_ratio_cont: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && rat_q[1] && sys[`RWRB_B_RAT_HI] |=> !ratio_reload_o && pll_base_512_o)
		else $error("relock on 10/11 change");
	a_ratio_relock: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && sys[`RWRB_B_RAT_HI:`RWRB_B_RAT_LO] != rat_q
		&& !(sys[`RWRB_B_RAT_HI] && rat_q[1]) |=> ratio_reload_o)
		else $error("ratio move without reload");
	a_half_bit: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i |=> output_clock_halving_o == $past(sys[`RWRB_B_HALF]))
		else $error("halving mismatch");
	a_amp_stop: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && sys[`RWRB_B_AMPSTOP] |=> !amp_run_o)
		else $error("amplifier not stopped");
	a_amp_cont: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && !sys[`RWRB_B_AMPSTOP] && sys[`RWRB_B_AMPCONT] |=> amp_run_o)
		else $error("amplifier not continuous");
	a_amp_auto: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && pll_locked_i && !sys[`RWRB_B_AMPCONT] |=> !amp_run_o)
		else $error("amplifier not auto stopped");
	a_src_unlock: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && !pll_locked_i |=> use_crystal_o)
		else $error("crystal source not used");
	a_src_force: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && sys[`RWRB_B_SRC] |=> use_crystal_o)
		else $error("crystal source not forced");
	a_src_locked: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i && pll_locked_i && !sys[`RWRB_B_SRC] |=> !use_crystal_o)
		else $error("crystal source while locked");
	a_xtal_code: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i |=> crystal_frequency_code_o == $past(sys[`RWRB_B_XF_HI:`RWRB_B_XF_LO]))
		else $error("crystal code mismatch");
	a_loopback: assert property (
		@(posedge clk_i) disable iff (!rst_s2_q)
		clk_en_i |=> crystal_loopback_o == $past(sys[`RWRB_B_XF_MSB]))
		else $error("loopback flag mismatch");
	c_sys_write: cover property (@(posedge clk_i) wr.we && wr.sel == SEL_SYS);
	c_irq_write: cover property (@(posedge clk_i) wr.we && wr.sel == SEL_IRQ);
	c_ratio_swap: cover property (@(posedge clk_i) rat_q == RAT_512 ##1 rat_q == RAT_512H);
	c_xtal_high: cover property (@(posedge clk_i) xtal == XF_33M);
	c_reload_seen: cover property (@(posedge clk_i) ratio_reload_o);
endmodule // rwrb_bank

// ### hw/rwrb_defs.svh
`ifndef RWRB_DEFS_SVH
`define RWRB_DEFS_SVH
`define RWRB_ADDR_SYS     8'hE8
`define RWRB_ADDR_PORT    8'hE9
`define RWRB_ADDR_IRQ     8'hEA
`define RWRB_ADDR_W       8
`define RWRB_DATA_W       16
`define RWRB_CNT_W        5
`define RWRB_SYS_RST      16'h0000
`define RWRB_PORT_RST     16'h0002
`define RWRB_IRQ_RST      16'h0000
`define RWRB_SYS_RSVD     16'h0102
`define RWRB_PORT_RSVD    16'h8800
`define RWRB_IRQ_RSVD     16'h00FE
`define RWRB_B_SRST       0
`define RWRB_B_PD_LO      2
`define RWRB_B_PD_HI      3
`define RWRB_B_VCO        4
`define RWRB_B_RAT_LO     5
`define RWRB_B_RAT_HI     6
`define RWRB_B_HALF       7
`define RWRB_B_AMPSTOP    9
`define RWRB_B_AMPCONT    10
`define RWRB_B_SRC        11
`define RWRB_B_XF_LO      12
`define RWRB_B_XF_HI      15
`define RWRB_B_XF_MSB     15
`define RWRB_CNT_FULL     5'h10
`define RWRB_CNT_ONE      5'h01
`define RWRB_CNT_ZERO     5'h00
`endif

// ### hw/rwrb_pkg.sv
package rwrb_pkg;
	typedef enum logic [1:0] {PD_NORMAL = 2'h0, PD_AMP = 2'h1, PD_AMP_DIV = 2'h2,
		PD_RSVD = 2'h3} rwrb_pd_t;
	typedef enum logic [1:0] {RAT_256 = 2'h0, RAT_384 = 2'h1, RAT_512 = 2'h2,
		RAT_512H = 2'h3} rwrb_ratio_t;
	typedef enum logic [2:0] {XF_11M = 3'h0, XF_12M = 3'h1, XF_16M = 3'h2, XF_22M = 3'h4,
		XF_24M = 3'h5, XF_33M = 3'h6, XF_RSVD = 3'h7} rwrb_xtal_t;
	typedef enum logic [1:0] {SEL_NONE = 2'h0, SEL_SYS = 2'h1, SEL_PORT = 2'h2,
		SEL_IRQ = 2'h3} rwrb_sel_t;
endpackage

// ### hw/rwrb_wr_if.sv
`timescale 1ns/10ps
interface rwrb_wr_if;
	logic        we;
	logic [1:0]  sel;
	logic [15:0] data;
	modport src (output we, output sel, output data);
	modport dst (input we, input sel, input data);
endinterface // rwrb_wr_if

// ### hw/rwrb_store.sv
`timescale 1ns/10ps
`include "rwrb_defs.svh"
module rwrb_store import rwrb_pkg::*; (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  ce_i,
	// Write port
	rwrb_wr_if.dst                     wr,
	// Register contents
	output logic [`RWRB_DATA_W-1:0]    sys_o,
	output logic [`RWRB_DATA_W-1:0]    port_o,
	output logic [`RWRB_DATA_W-1:0]    irq_o
);
	logic [`RWRB_DATA_W-1:0] sys_d, port_d, irq_d, sys_q, port_q, irq_q;

	// Reserved bits forced low even if host misbehaves
	always_comb begin
		sys_d  = sys_q;
		port_d = port_q;
		irq_d  = irq_q;
		if (wr.we) begin
			unique case (rwrb_sel_t'(wr.sel))
				SEL_SYS:  sys_d  = wr.data & ~`RWRB_SYS_RSVD;
				SEL_PORT: port_d = wr.data & ~`RWRB_PORT_RSVD;
				SEL_IRQ:  irq_d  = wr.data & ~`RWRB_IRQ_RSVD;
				SEL_NONE: ;
			endcase
		end
	end

	// Only power-on reset clears; soft reset never reaches here
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sys_q  <= `RWRB_SYS_RST;
			port_q <= `RWRB_PORT_RST;
			irq_q  <= `RWRB_IRQ_RST;
		end else if (ce_i) begin
			sys_q  <= sys_d;
			port_q <= port_d;
			irq_q  <= irq_d;
		end
	end

	assign sys_o  = sys_q;
	assign port_o = port_q;
	assign irq_o  = irq_q;
endmodule // rwrb_store

// ### testbench/rwrb_host_model.sv
`timescale 1ns/10ps
module rwrb_host_model (
	// Clock
	input  wire logic       clk_i,
	// Serial command port
	output logic            scl_o,
	output logic            sdi_o,
	output logic            ce_o,
	output logic [7:0]      addr_o,
	output logic            addr_valid_o
);
	initial begin
		scl_o        = 1'b0;
		sdi_o        = 1'b0;
		ce_o         = 1'b0;
		addr_o       = 8'h00;
		addr_valid_o = 1'b0;
	end

	// Slow host, two system clocks per serial phase; serial clock idles low
	task automatic send(input logic [7:0] a, input logic [15:0] d, input int n);
		@(negedge clk_i);
		addr_o       = a;
		addr_valid_o = 1'b1;
		ce_o         = 1'b0;
		@(negedge clk_i);
		addr_valid_o = 1'b0;
		addr_o       = ~a;
		ce_o         = 1'b1;
		for (int k = 0; k < n; k++) begin
			sdi_o = d[k % 16];
			repeat (2) @(negedge clk_i);
			scl_o = 1'b1;
			repeat (2) @(negedge clk_i);
			scl_o = 1'b0;
		end
		ce_o  = 1'b0;
		// Released line must not keep the last bit
		sdi_o = ~sdi_o;
		@(negedge clk_i);
	endtask
endmodule // rwrb_host_model

// ### testbench/tb_receiver_write_register_bank.sv
`timescale 1ns/10ps
`include "rwrb_defs.svh"
module tb_receiver_write_register_bank;
	logic        clk_i, rst_n_i, lock, scl, sdi, ce, av, seen, reload;
	logic        srst, vco, b512, ph, halv, amp, xtal, loopb;
	logic [7:0]  addr;
	logic [1:0]  pd, rat;
	logic [3:0]  xcode;
	logic [15:0] port_s, irq_s, m_sys, m_port, m_irq;
	logic [47:0] exp_q [$];
	logic [47:0] got;
	int          fail_count, total_checks, cycles;
	integer      seed;
	event        chk;

	rwrb_host_model u_host (.clk_i(clk_i), .scl_o(scl), .sdi_o(sdi), .ce_o(ce),
		.addr_o(addr), .addr_valid_o(av));

	rwrb_bank u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
		.command_serial_clock_i(scl), .command_serial_in_i(sdi), .chip_enable_i(ce),
		.addr_i(addr), .addr_valid_i(av), .pll_locked_i(lock), .soft_reset_o(srst),
		.power_down_mode_o(pd), .vco_run_o(vco), .locked_clock_ratio_o(rat),
		.pll_base_512_o(b512), .pll_post_half_o(ph), .output_clock_halving_o(halv),
		.amp_run_o(amp), .use_crystal_o(xtal), .crystal_frequency_code_o(xcode),
		.crystal_loopback_o(loopb), .ratio_reload_o(reload), .port_settings_o(port_s),
		.irq_settings_o(irq_s));

	always #5 clk_i = ~clk_i;

	function automatic logic [47:0] expect_f(input logic [15:0] s, input logic lk);
		logic [1:0] p;
		// Reserved power code reads back as normal
		p = (s[3:2] == 2'h3) ? 2'h0 : s[3:2];
		return {s[0], p, ~s[4], s[6:5], s[6], &s[6:5], s[7], ~s[9] & (s[10] | ~lk),
			s[11] | ~lk, s[15:12], s[15], m_port, m_irq};
	endfunction

	task automatic compare(input logic [47:0] e, input logic [47:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic compare_flag(input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic note();
		exp_q.push_back(expect_f(m_sys, lock));
		->chk;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d, input int n);
		logic [15:0] v;
		v = d & ~((a == `RWRB_ADDR_SYS) ? `RWRB_SYS_RSVD :
			(a == `RWRB_ADDR_PORT) ? `RWRB_PORT_RSVD : `RWRB_IRQ_RSVD);
		u_host.send(a, v, n);
		if (n >= 16) begin
			case (a)
				`RWRB_ADDR_SYS:  m_sys = v;
				`RWRB_ADDR_PORT: m_port = v;
				`RWRB_ADDR_IRQ:  m_irq = v;
				default: ;
			endcase
		end
		// Decoded outputs settle three cycles after the last bit
		repeat (4) @(negedge clk_i);
		note();
	endtask

	task automatic complete_run();
		$display("checks=%0d errors=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	assign got = {srst, pd, vco, rat, b512, ph, halv, amp, xtal, xcode, loopb,
		port_s, irq_s};

	always @(chk) compare(exp_q.pop_front(), got);

	always @(posedge clk_i) begin
		if (reload === 1'b1)
			seen = 1'b1;
		cycles++;
		if (cycles == 10000) begin
			fail_count++;
			complete_run();
		end
	end

	initial begin
		seed = 85;
		clk_i = 1'b0;
		rst_n_i = 1'b0;
		lock = 1'b0;
		seen = 1'b0;
		m_sys = `RWRB_SYS_RST;
		m_port = `RWRB_PORT_RST;
		m_irq = `RWRB_IRQ_RST;
		repeat (2) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge clk_i);
		note();
		for (int i = 0; i < 16; i++)
			wr(`RWRB_ADDR_SYS, {4{i[3:0]}}, 16);
		for (int i = 0; i < 24; i++) begin
			lock = 1'($random(seed));
			wr(8'hE8 + 8'(i % 3), 16'($random(seed)), 16);
		end
		wr(`RWRB_ADDR_SYS, 16'h0040, 16);
		seen = 1'b0;
		wr(`RWRB_ADDR_SYS, 16'h0060, 16);
		wr(`RWRB_ADDR_SYS, 16'h0040, 16);
		compare_flag(1'b0, seen);
		wr(`RWRB_ADDR_SYS, 16'h0000, 16);
		compare_flag(1'b1, seen);
		// Partial word must be dropped, overlong word keeps its first sixteen bits
		wr(`RWRB_ADDR_PORT, 16'($random(seed)), 15);
		wr(`RWRB_ADDR_IRQ, 16'($random(seed)), 17);
		wr(8'hEB, 16'($random(seed)), 16);
		// Let the pending compare run before reset disturbs the outputs
		@(negedge clk_i);
		rst_n_i = 1'b0;
		repeat (2) @(negedge clk_i);
		rst_n_i = 1'b1;
		m_sys = `RWRB_SYS_RST;
		m_port = `RWRB_PORT_RST;
		m_irq = `RWRB_IRQ_RST;
		repeat (4) @(negedge clk_i);
		note();
		wr(`RWRB_ADDR_IRQ, 16'($random(seed)), 16);
		@(negedge clk_i);
		complete_run();
	end
endmodule // tb_receiver_write_register_bank
